// ---- src/wfpd_map.svh ----
// Purpose: register offsets, bit positions and constants of the wake detector
// Assumes: 32-bit AXI4-Lite words, byte addresses
// Notes:   included by bare name
`ifndef WFPD_MAP_SVH
`define WFPD_MAP_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define WFPD_PORT_OFS   8'h00
`define WFPD_CSR_OFS    8'h04
// ----------------------------------------------------------------
// control/status bit positions
// ----------------------------------------------------------------
`define WFPD_PKT_EN_BIT 1
`define WFPD_FRM_EN_BIT 2
`define WFPD_PKT_RX_BIT 4
`define WFPD_FRM_RX_BIT 5
`define WFPD_IRQ_EN_BIT 8
`define WFPD_PME_EN_BIT 9
// ----------------------------------------------------------------
// filter words and fields
// ----------------------------------------------------------------
`define WFPD_NWORDS     8
`define WFPD_CMD_WORD   4
`define WFPD_OFF_WORD   5
`define WFPD_CRC_WORD   6
`define WFPD_CMD_EN     0
`define WFPD_CMD_MCAST  3
`define WFPD_MASK_LEN   31
`define WFPD_MIN_OFS    12
`define WFPD_WORD_RST   32'h0000_0000
// ----------------------------------------------------------------
// crc, wake packet shape and bus response codes
// ----------------------------------------------------------------
`define WFPD_CRC_POLY   16'h8005
`define WFPD_CRC_INIT   16'hffff
`define WFPD_SYNC_LEN   3'h6
`define WFPD_ADDR_REPS  4'hf
`define WFPD_RESP_OK    2'h0
`define WFPD_RESP_ERR   2'h2
`endif

// ---- src/wfpd_pkg.sv ----
// Purpose: shared types of the wake detector
// Assumes: nothing
// Notes:   constants live in wfpd_map.svh
package wfpd_pkg;
  typedef enum logic [1:0] {PS_SYNC, PS_ADDR, PS_DONE} wfpd_scan_e;
  typedef logic [10:0] wfpd_idx_t;
endpackage : wfpd_pkg

// ---- src/wfpd_rx_if.sv ----
// Purpose: receive byte stream between the top and the packet scanner
// Assumes: one byte per valid cycle
// Notes:   destOk is stable from byte 6 onward
`timescale 1ns/100ps
interface wfpd_rx_if;
  logic            valid;
  logic            sof;
  logic [7:0]      data;
  logic [10:0]     idx;
  logic            destOk;
  modport src  (output valid, sof, data, idx, destOk);
  modport sink (input  valid, sof, data, idx, destOk);
endinterface : wfpd_rx_if

// ---- src/wfpd_pkt_scan.sv ----
// Purpose: wake packet scanner (sync run then sixteen address copies)
// Assumes: bytes arrive in frame order
// Notes:   found is a one-cycle pulse from a flop
`timescale 1ns/100ps
`include "wfpd_map.svh"
module wfpd_pkt_scan import wfpd_pkg::*; (
  // clock and reset
  input wire logic  clk,
  input wire logic  rst_n,
  // byte stream
  wfpd_rx_if.sink   rx,
  // setup and result
  input wire logic [47:0] stationAddr,
  input wire logic  scanOn,
  output logic      found
);
  wfpd_scan_e  state_q;
  logic [2:0]  ffCnt_q;
  logic [2:0]  pos_q;
  logic [3:0]  rep_q;
  logic        found_q;
  logic        live;
  logic        isFf;
  logic        addrHit;

  function automatic logic [7:0] addrByte(input logic [47:0] a, input logic [2:0] p);
    return a[8*p +: 8];
  endfunction

  // scan only after both address fields of an eligible frame
  assign live    = scanOn && rx.valid && !rx.sof && rx.destOk && rx.idx >= 11'd12;
  assign isFf    = rx.data == 8'hff;
  assign addrHit = rx.data == addrByte(stationAddr, pos_q);
  assign found   = found_q;

  // ----------------------------------------------------------------
  // scanner state machine
  // ----------------------------------------------------------------
  // RULE11 sync stream search
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PS_SYNC;
      ffCnt_q <= 3'h0;
      pos_q   <= 3'h0;
      rep_q   <= 4'h0;
      found_q <= 1'b0;
    end else begin
      found_q <= 1'b0;
      if (rx.valid && rx.sof) begin
        state_q <= PS_SYNC;
        ffCnt_q <= 3'h0;
        pos_q   <= 3'h0;
      end else if (live) begin
        case (state_q)
          PS_SYNC: begin
            // RULE14 sync may start at any byte
            if (isFf) begin
              ffCnt_q <= (ffCnt_q == `WFPD_SYNC_LEN) ? ffCnt_q : ffCnt_q + 3'h1;
            end else if (ffCnt_q == `WFPD_SYNC_LEN && addrHit) begin
              state_q <= PS_ADDR;
              pos_q   <= 3'h1;
              rep_q   <= 4'h0;
            end else begin
              ffCnt_q <= 3'h0;
            end
          end
          PS_ADDR: begin
            // RULE12 sixteen copies back to back
            if (addrHit) begin
              if (pos_q == 3'h5) begin
                pos_q <= 3'h0;
                rep_q <= rep_q + 4'h1;
                if (rep_q == `WFPD_ADDR_REPS) begin
                  state_q <= PS_DONE;
                  found_q <= 1'b1;
                end
              end else begin
                pos_q <= pos_q + 3'h1;
              end
            end else begin
              // RULE13 break restarts the search
              state_q <= PS_SYNC;
              ffCnt_q <= isFf ? 3'h1 : 3'h0;
              pos_q   <= 3'h0; // a cut copy must not skew the next sync match
            end
          end
          PS_DONE: state_q <= PS_DONE;
          default: state_q <= PS_SYNC;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_found_after_reps: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    found |-> $past(rep_q) == `WFPD_ADDR_REPS && $past(pos_q) == 3'h5)
    else $error("found without sixteen copies");
  a_break_resyncs: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
    live && state_q == PS_ADDR && !addrHit |=> state_q == PS_SYNC)
    else $error("broken copy run did not restart");
  c_found: cover property (@(posedge clk) disable iff (!rst_n) found);
endmodule // wfpd_pkt_scan

// ---- src/wfpd_top.sv ----
// Purpose: wake frame pattern filters and wake packet detection
// Assumes: receive bytes synchronous to clk, stationAddr stable
// Notes:   registers over AXI4-Lite, one transfer each way at a time
// Operation
// RULE1: mask bit j selects byte offset plus j
// RULE2: command address type picks multicast or unicast
// RULE3: command bit zero enables the filter
// RULE4: software keeps offsets at twelve or more
// RULE5: offsets count from first destination byte
// RULE6: masked-byte crc equal to stored crc matches
// RULE7: packet enable halts normal reception, runs scan
// RULE8: packet detect sets status, irq or event
// RULE9: clearing packet enable restores normal reception
// RULE10: scan only own or broadcast frames
// RULE11: search for six all-ones sync bytes
// RULE12: sixteen back-to-back address copies required
// RULE13: broken copy run restarts sync search
// RULE14: sync and copies may start anywhere
// RULE15: multicast frames with copies also accepted
// RULE16: D1 state forces both detectors on
// RULE17: frame enable runs filters, sets received status
// RULE18: four independent filters with own fields
// RULE19: software loads filters by eight port writes
// RULE20: broadcast match ignores broadcast disable setting
// RULE21: match judged at frame end, not on fcs errors
`timescale 1ns/100ps
`include "wfpd_map.svh"
module wfpd_top import wfpd_pkg::*; #(
  parameter int NFILT = 4,
  parameter int AW    = 8
)(
  // clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // axi4-lite write
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic          s_axi_awvalid,
  output logic              s_axi_awready,
  input wire logic [31:0]   s_axi_wdata,
  input wire logic [3:0]    s_axi_wstrb,
  input wire logic          s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input wire logic          s_axi_bready,
  // axi4-lite read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input wire logic          s_axi_rready,
  // receive datapath
  input wire logic          rxValid,
  input wire logic          rxSof,
  input wire logic          rxEof,
  input wire logic [7:0]    rxData,
  input wire logic          rxFcsErr,
  // mac setup and power state
  input wire logic [47:0]   stationAddr,
  input wire logic          broadcastDisable,
  input wire logic          powerStateD1,
  // results
  output logic              normalRxEnable,
  output logic              wakeIrq,
  output logic              powerEventOut
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0] word_q [`WFPD_NWORDS];
  logic [2:0]  wPtr_q, rPtr_q;
  logic        awHeld_q, wHeld_q, bvalid_q, rvalid_q;
  logic [AW-1:0] awAddr_q;
  logic [31:0] wData_q, rData_q;
  logic [3:0]  wStrb_q;
  logic [1:0]  bResp_q, rResp_q;
  logic        doWr, doRd, wrPort, wrCsr, rdPort;
  logic        pktEn_q, frmEn_q, irqEn_q, pmeEn_q;
  logic        pktRx_q, frmRx_q, irq_q, pme_q;
  logic [31:0] csrRd, csrNew;
  wfpd_idx_t   idx, byteCnt_q;
  logic [47:0] destBuf_q;
  logic        destMcast, destOwn, frameOn, packetOn, frameEnd;
  logic [15:0] crc_q [NFILT];
  logic [15:0] crcNext [NFILT];
  logic [NFILT-1:0] sel, match;
  logic        pktFound;
  wfpd_rx_if   rx ();

  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int b = 0; b < 8; b++) begin
      if (r[15] ^ d[7-b]) r = {r[14:0], 1'b0} ^ `WFPD_CRC_POLY;
      else r = {r[14:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int k = 0; k < 4; k++) if (s[k]) r[8*k +: 8] = n[8*k +: 8];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !awHeld_q && !bvalid_q;
  assign s_axi_wready  = !wHeld_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bResp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rData_q;
  assign s_axi_rresp   = rResp_q;
  assign doWr   = awHeld_q && wHeld_q && !bvalid_q;
  assign doRd   = s_axi_arvalid && !rvalid_q;
  assign wrPort = doWr && awAddr_q == AW'(`WFPD_PORT_OFS);
  assign wrCsr  = doWr && awAddr_q == AW'(`WFPD_CSR_OFS);
  assign rdPort = doRd && s_axi_araddr == AW'(`WFPD_PORT_OFS);

  // address and data are caught in either order, answered when both held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= '0;
      wData_q  <= 32'h0;
      wStrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bResp_q  <= `WFPD_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWr) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bResp_q  <= (wrPort || wrCsr) ? `WFPD_RESP_OK : `WFPD_RESP_ERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read data is registered; unmapped addresses answer slverr
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rData_q  <= 32'h0;
      rResp_q  <= `WFPD_RESP_OK;
    end else if (doRd) begin
      rvalid_q <= 1'b1;
      rResp_q  <= `WFPD_RESP_OK;
      if (rdPort) rData_q <= word_q[rPtr_q];
      else if (s_axi_araddr == AW'(`WFPD_CSR_OFS)) rData_q <= csrRd;
      else begin
        rData_q <= 32'h0;
        rResp_q <= `WFPD_RESP_ERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // filter port: eight words reached through one address
  // ----------------------------------------------------------------
  // RULE19 successive port writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int k = 0; k < `WFPD_NWORDS; k++) word_q[k] <= `WFPD_WORD_RST;
      wPtr_q <= 3'h0;
      rPtr_q <= 3'h0;
    end else begin
      if (wrPort) begin
        word_q[wPtr_q] <= merge(word_q[wPtr_q], wData_q, wStrb_q);
        wPtr_q <= wPtr_q + 3'h1;
      end
      if (rdPort) rPtr_q <= rPtr_q + 3'h1;
      // a control write rewinds both pointers to word zero
      if (wrCsr) begin
        wPtr_q <= 3'h0;
        rPtr_q <= 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control and status
  // ----------------------------------------------------------------
  always_comb begin
    csrRd = 32'h0;
    csrRd[`WFPD_PKT_EN_BIT] = pktEn_q;
    csrRd[`WFPD_FRM_EN_BIT] = frmEn_q;
    csrRd[`WFPD_PKT_RX_BIT] = pktRx_q;
    csrRd[`WFPD_FRM_RX_BIT] = frmRx_q;
    csrRd[`WFPD_IRQ_EN_BIT] = irqEn_q;
    csrRd[`WFPD_PME_EN_BIT] = pmeEn_q;
  end

  assign csrNew = merge(csrRd, wData_q, wStrb_q);
  // enables are plain bits; received flags clear on write-one, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pktEn_q <= 1'b0;
      frmEn_q <= 1'b0;
      irqEn_q <= 1'b0;
      pmeEn_q <= 1'b0;
      pktRx_q <= 1'b0;
      frmRx_q <= 1'b0;
    end else begin
      if (wrCsr) begin
        pktEn_q <= csrNew[`WFPD_PKT_EN_BIT];
        frmEn_q <= csrNew[`WFPD_FRM_EN_BIT];
        irqEn_q <= csrNew[`WFPD_IRQ_EN_BIT];
        pmeEn_q <= csrNew[`WFPD_PME_EN_BIT];
      end
      // RULE8 packet received status
      pktRx_q <= pktFound ||
        (pktRx_q && !(wrCsr && wStrb_q[0] && wData_q[`WFPD_PKT_RX_BIT]));
      // RULE17 frame received status
      frmRx_q <= (|match) ||
        (frmRx_q && !(wrCsr && wStrb_q[0] && wData_q[`WFPD_FRM_RX_BIT]));
    end
  end

  // RULE8 notify host or power event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
      pme_q <= 1'b0;
    end else begin
      irq_q <= irqEn_q && (pktRx_q || frmRx_q);
      pme_q <= pmeEn_q && (pktRx_q || frmRx_q);
    end
  end
  assign wakeIrq       = irq_q;
  assign powerEventOut = pme_q;

  // RULE16 low-power state forces detection on
  assign frameOn  = frmEn_q || powerStateD1;
  assign packetOn = pktEn_q || powerStateD1;
  // RULE7 RULE9 normal reception only with both detectors off
  assign normalRxEnable = !(frameOn || packetOn);

  // ----------------------------------------------------------------
  // frame byte position and destination address
  // ----------------------------------------------------------------
  // RULE5 offset zero is the first destination byte
  assign idx = rxSof ? 11'h0 : byteCnt_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byteCnt_q <= 11'h0;
      destBuf_q <= 48'h0;
    end else if (rxValid) begin
      byteCnt_q <= (idx == 11'h7ff) ? idx : idx + 11'h1;
      if (idx < 11'd6) destBuf_q[8*idx[2:0] +: 8] <= rxData;
    end
  end
  // RULE20 broadcast counts as multicast here; broadcastDisable is not consulted
  assign destMcast = destBuf_q[0];
  assign destOwn   = destBuf_q == stationAddr;
  assign frameEnd  = rxValid && rxEof && frameOn && idx >= 11'd6;

  // ----------------------------------------------------------------
  // pattern filters
  // ----------------------------------------------------------------
  // RULE18 one crc engine per filter
  always_comb begin
    wfpd_idx_t   rel;
    logic [15:0] base;
    logic [7:0]  cmd;
    rel = 11'h0;
    base = 16'h0;
    cmd = 8'h0;
    for (int i = 0; i < NFILT; i++) begin
      rel  = idx - {3'h0, word_q[`WFPD_OFF_WORD][8*i +: 8]};
      cmd  = word_q[`WFPD_CMD_WORD][8*i +: 8];
      base = rxSof ? `WFPD_CRC_INIT : crc_q[i];
      // RULE1 RULE5 masked window from the offset
      sel[i] = idx >= {3'h0, word_q[`WFPD_OFF_WORD][8*i +: 8]} &&
               rel < 11'(`WFPD_MASK_LEN) && word_q[i][rel[4:0]];
      crcNext[i] = sel[i] ? crcByte(base, rxData) : base;
      // RULE2 RULE3 RULE6 RULE21 type, enable, crc, good fcs at end
      match[i] = frameEnd && !rxFcsErr && cmd[`WFPD_CMD_EN] &&
                 (cmd[`WFPD_CMD_MCAST] ? destMcast : destOwn) &&
                 crcNext[i] == word_q[`WFPD_CRC_WORD + i/2][16*(i%2) +: 16];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NFILT; i++) crc_q[i] <= `WFPD_CRC_INIT;
    end else if (rxValid) begin
      for (int i = 0; i < NFILT; i++) crc_q[i] <= crcNext[i];
    end
  end

  // ----------------------------------------------------------------
  // wake packet scanner
  // ----------------------------------------------------------------
  assign rx.valid  = rxValid;
  assign rx.sof    = rxSof;
  assign rx.data   = rxData;
  assign rx.idx    = idx;
  // RULE10 RULE15 own, broadcast or multicast destinations
  assign rx.destOk = destOwn || destMcast;

  wfpd_pkt_scan u_scan (
    .clk         (clk),
    .rst_n       (rst_n),
    .rx          (rx.sink),
    .stationAddr (stationAddr),
    .scanOn      (packetOn),
    .found       (pktFound)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_disabled_no_match: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
    !word_q[`WFPD_CMD_WORD][8*(NFILT-1)+`WFPD_CMD_EN] |-> !match[NFILT-1])
    else $error("disabled filter matched");
  a_type_multicast: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
    match[NFILT-1] && word_q[`WFPD_CMD_WORD][8*(NFILT-1)+`WFPD_CMD_MCAST] |-> destMcast)
    else $error("multicast filter matched unicast");
  a_mask_skips: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    rxValid && !rxSof && !sel[NFILT-1] |=> crc_q[NFILT-1] == $past(crc_q[NFILT-1]))
    else $error("unmasked byte changed crc");
  a_before_offset: assert property (@(posedge clk) disable iff (!rst_n) // RULE5
    idx < {3'h0, word_q[`WFPD_OFF_WORD][8*(NFILT-1) +: 8]} |-> !sel[NFILT-1])
    else $error("byte before offset used");
  a_fcs_err_drops: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
    rxFcsErr || !rxEof |-> match == '0)
    else $error("match outside good frame end");
  a_frame_status: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    |match |=> frmRx_q ##1 (frmRx_q || $past(wrCsr && wData_q[`WFPD_FRM_RX_BIT])))
    else $error("frame match lost");
  a_pkt_irq: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    pktFound && irqEn_q && !wrCsr ##1 !wrCsr |=> wakeIrq)
    else $error("packet found without irq");
  a_rx_halted: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    pktEn_q || powerStateD1 |-> !normalRxEnable && packetOn && frameOn == (frmEn_q || powerStateD1))
    else $error("normal reception during scan");
  a_rx_resumes: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    $fell(pktEn_q) && !frmEn_q && !powerStateD1 |-> normalRxEnable)
    else $error("reception not restored");
  c_filter_match: cover property (@(posedge clk) disable iff (!rst_n) |match);
  c_pkt_found: cover property (@(posedge clk) disable iff (!rst_n) pktFound);
  c_d1_wake: cover property (@(posedge clk) disable iff (!rst_n) powerStateD1 ##1 pme_q);
endmodule // wfpd_top

// ---- dv/wfpd_rx_model.sv ----
// Purpose: receive datapath model that feeds frames to the detector
// Assumes: one byte per cycle, bytes in frame order
// Notes:   idle data toggles so that a stale byte never passes as valid
`timescale 1ns/100ps
module wfpd_rx_model (
  // clock
  input  wire logic       clk,
  // byte stream
  output logic            rxValid,
  output logic            rxSof,
  output logic            rxEof,
  output logic [7:0]      rxData,
  output logic            rxFcsErr
);
  logic busy = 1'b0;
  initial {rxValid, rxSof, rxEof, rxData, rxFcsErr} = '0;
  // one frame back to back, fcs flag rides on the last byte only
  task automatic send(input logic [7:0] f[$], input logic bad);
    busy = 1'b1;
    for (int i = 0; i < f.size(); i++) begin
      @(posedge clk);
      rxValid  <= 1'b1;
      rxSof    <= (i == 0);
      rxEof    <= (i == f.size() - 1);
      rxData   <= f[i];
      rxFcsErr <= bad && (i == f.size() - 1);
    end
    @(posedge clk);
    {rxValid, rxSof, rxEof, rxFcsErr} <= '0;
    busy = 1'b0;
  endtask
  // released data line changes every cycle
  always @(posedge clk) if (!busy) rxData <= ~rxData;
endmodule // wfpd_rx_model

// ---- dv/wfpd_top_tb.sv ----
// Purpose: self-checking bench of the wake detector
// Assumes: axi master keeps one transfer each way at a time
// Notes:   bus answers are checked against a queue of notes
`timescale 1ns/100ps
`include "wfpd_map.svh"
module wfpd_top_tb;
  localparam logic [7:0]  PORT = `WFPD_PORT_OFS;
  localparam logic [7:0]  CSR  = `WFPD_CSR_OFS;
  localparam logic [31:0] PKT_EN = 32'h1 << `WFPD_PKT_EN_BIT;
  localparam logic [31:0] FRM_EN = 32'h1 << `WFPD_FRM_EN_BIT;
  localparam logic [31:0] PKT_RX = 32'h1 << `WFPD_PKT_RX_BIT;
  localparam logic [31:0] FRM_RX = 32'h1 << `WFPD_FRM_RX_BIT;
  localparam logic [31:0] IRQ_EN = 32'h1 << `WFPD_IRQ_EN_BIT;
  localparam logic [31:0] PME_EN = 32'h1 << `WFPD_PME_EN_BIT;
  logic        clk = 1'b0, rst_n = 1'b0;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, rxData, off;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        rxValid, rxSof, rxEof, rxFcsErr, broadcastDisable, powerStateD1;
  logic        normalRxEnable, wakeIrq, powerEventOut;
  logic [47:0] stationAddr;
  logic [15:0] crc;
  logic [33:0] expq[$];
  logic [7:0]  fr[$];
  logic [31:0] w[8];
  int          err_total = 0, n_checks = 0, seed = 32'h6b04;

  wfpd_top u_wfpd_top (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxValid, .rxSof, .rxEof,
    .rxData, .rxFcsErr, .stationAddr, .broadcastDisable, .powerStateD1, .normalRxEnable,
    .wakeIrq, .powerEventOut);
  wfpd_rx_model u_wfpd_rx_model (.clk, .rxValid, .rxSof, .rxEof, .rxData, .rxFcsErr);

  // 25 mhz clock
  always #20 clk = ~clk;

  task automatic complete_run;
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bus answers popped in order; response code kept above the data
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, expq.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
  end
  // each channel released at its own take, the response awaited without a count
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic aw, wd;
    aw = 1'b0;
    wd = 1'b0;
    expq.push_back({r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw && wd)) begin
      @(posedge clk);
      if (!aw && s_axi_awready) begin aw = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!wd && s_axi_wready) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
    expq.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic load(input logic [31:0] ctrl, input logic [31:0] cmd);
    axi_wr(CSR, ctrl);
    w[4] = cmd;
    foreach (w[i]) axi_wr(PORT, w[i]);
  endtask
  // frame helpers: header with random source, sync run plus address copies
  task automatic hdr(input logic [47:0] d);
    fr.delete();
    for (int i = 0; i < 6; i++) fr.push_back(d[8*i +: 8]);
    repeat (6) fr.push_back(8'($random(seed)) & 8'h7f);
  endtask
  task automatic magic(input int reps);
    repeat (6) fr.push_back(8'hff);
    repeat (reps) for (int i = 0; i < 6; i++) fr.push_back(stationAddr[8*i +: 8]);
  endtask
  task automatic xmit(input logic bad, input logic [31:0] e);
    u_wfpd_rx_model.send(fr, bad);
    repeat (4) @(posedge clk);
    axi_rd(CSR, {2'h0, e});
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h8005 : 16'h0);
    return c;
  endfunction

  // watchdog
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    complete_run();
  end
  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, broadcastDisable, powerStateD1} = '0;
    stationAddr = {8'h3c, 32'($random(seed)) & 32'h7f7f7f7f, 8'h02};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    axi_rd(CSR, 34'h0);
    chk(normalRxEnable, 1'b1);
    axi_rd(8'h08, {2'h2, 32'h0});
    axi_wr(8'h0c, 32'h1, 2'h2);
    // filter three carries the pattern, the others stay empty
    foreach (w[i]) w[i] = 32'h0;
    off = 8'd12 + (8'($random(seed)) & 8'h07);
    w[3] = 32'($random(seed)) & 32'h7fff_ffff;
    w[5] = {off, 24'h0};
    hdr(stationAddr);
    repeat (off + 19) fr.push_back(8'($random(seed)));
    crc = 16'hffff;
    for (int j = 0; j < 31; j++) if (w[3][j]) crc = crc16(crc, fr[off + j]);
    w[7] = {crc, 16'h0};
    load(FRM_EN, 32'h0100_0000);
    chk(normalRxEnable, 1'b0);
    axi_wr(CSR, FRM_EN);
    foreach (w[i]) axi_rd(PORT, {2'h0, w[i]});
    xmit(1'b0, FRM_EN | FRM_RX);
    axi_wr(CSR, FRM_EN | FRM_RX);
    xmit(1'b1, FRM_EN);
    load(FRM_EN, 32'h0);
    xmit(1'b0, FRM_EN);
    load(FRM_EN, 32'h0900_0000);
    xmit(1'b0, FRM_EN);
    for (int i = 0; i < 6; i++) fr[i] = 8'hff;
    broadcastDisable <= 1'b1;
    xmit(1'b0, FRM_EN | FRM_RX);
    axi_wr(CSR, FRM_RX);
    chk(normalRxEnable, 1'b1);
    // wake packet scanning with interrupt
    axi_wr(CSR, PKT_EN | IRQ_EN);
    chk(normalRxEnable, 1'b0);
    hdr(stationAddr);
    fr.push_back(8'h11);
    magic(16);
    xmit(1'b0, PKT_EN | IRQ_EN | PKT_RX);
    chk({wakeIrq, powerEventOut}, 2'b10);
    axi_wr(CSR, PKT_EN | IRQ_EN | PKT_RX);
    hdr(stationAddr);
    magic(15);
    xmit(1'b0, PKT_EN | IRQ_EN);
    hdr(stationAddr);
    magic(9);
    fr.push_back(stationAddr[7:0]);
    fr.push_back(8'h00);
    magic(16);
    xmit(1'b0, PKT_EN | IRQ_EN | PKT_RX);
    axi_wr(CSR, PKT_EN | IRQ_EN | PKT_RX);
    hdr(stationAddr ^ 48'h100);
    magic(16);
    xmit(1'b0, PKT_EN | IRQ_EN);
    hdr({stationAddr[47:8], 8'h03});
    magic(16);
    xmit(1'b0, PKT_EN | IRQ_EN | PKT_RX);
    axi_wr(CSR, PKT_RX);
    hdr(stationAddr);
    magic(16);
    xmit(1'b0, 32'h0);
    chk(normalRxEnable, 1'b1);
    // low power state forces detection on
    powerStateD1 <= 1'b1;
    axi_wr(CSR, PME_EN);
    chk(normalRxEnable, 1'b0);
    xmit(1'b0, PME_EN | PKT_RX);
    chk({wakeIrq, powerEventOut}, 2'b01);
    complete_run();
  end
endmodule // wfpd_top_tb
